// [pkg/disp_timing_consts.vh]
/*
  Constants for the display pipe timing generator: format codes, line and
  pixel totals per format, active widths, and the pixel clock limits.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef DISP_TIMING_CONSTS_VH
`define DISP_TIMING_CONSTS_VH

// ----------------------------------------------------------------------
// Format codes
// ----------------------------------------------------------------------
`define FMT_480I_720  4'h0
`define FMT_480I_640  4'h1
`define FMT_480P_720  4'h2
`define FMT_480P_640  4'h3
`define FMT_720P      4'h4
`define FMT_1080I     4'h5
`define FMT_1080P     4'h6
`define FMT_576I      4'h7
`define FMT_768P_1280 4'h8
`define FMT_768P_1366 4'h9

// ----------------------------------------------------------------------
// Totals and active sizes
// ----------------------------------------------------------------------
`define VTOT_480  12'h20d
`define HTOT_480  12'h35a
`define VTOT_720  12'h2ee
`define HTOT_720  12'h672
`define VTOT_1080 12'h465
`define HTOT_1080 12'h898
`define VTOT_576  12'h271
`define HTOT_576  12'h360
`define VTOT_768A 12'h322
`define HTOT_768A 12'h698
`define VTOT_768B 12'h325
`define HTOT_768B 12'h678
`define VACT_480  12'h1e0
`define VACT_720  12'h2d0
`define VACT_1080 12'h438
`define VACT_576  12'h240
`define VACT_768  12'h300
`define HACT_720  12'h2d0
`define HACT_640  12'h280
`define HACT_1280 12'h500
`define HACT_1920 12'h780
`define HACT_1366 12'h556

// ----------------------------------------------------------------------
// Border, porch and sync widths (uniform choice for all formats)
// ----------------------------------------------------------------------
`define BORDER_W  12'h008
`define HFP_W     12'h008
`define HSYNC_W   12'h020
`define VFP_L     12'h003
`define VSYNC_L   12'h003
`define BORDER_L  12'h001

// ----------------------------------------------------------------------
// Pixel clock limits in MHz, system clock in MHz and ns
// ----------------------------------------------------------------------
`define PCLK_SINGLE_MHZ 165
`define PCLK_DUAL_MHZ   330
`define SYNC_CLK_MHZ    125
`define SYNC_CLK_NS     8

`endif

// [src/display_pipe_timing_generator.v]
/*
  Timing generator for the first display pipe: counts pixels and lines on
  each rising pixel clock edge, decodes active, border, blank and sync, marks
  interlaced fields, and routes buffered pixels to the two digital ports.
  Assumes pixel data arrives on clk_i with valid/ready and that the pixel
  clock pin is sampled here, not used as a clock.
*/
`timescale 1ns/1ps
`include "disp_timing_consts.vh"
module display_pipe_timing_generator #(
  parameter DW = 24,
  parameter FIFO_DEPTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire pix_clk_i,
  input wire native_strap_i,
  input wire [3:0] format_i,
  input wire dual_port_i,
  input wire port_b_sel_pipe_b_i,
  input wire port_c_sel_pipe_b_i,
  input wire pix_valid_i,
  output wire pix_ready_o,
  input wire [DW-1:0] pix_data_i,
  input wire [DW-1:0] pipe_b_data_i,
  output reg hsync_o,
  output reg vsync_o,
  output reg hblank_o,
  output reg vblank_o,
  output reg border_o,
  output reg active_o,
  output reg field_identity_o,
  output reg underrun_o,
  output reg [DW-1:0] digital_port_b_o,
  output reg [DW-1:0] digital_port_c_o,
  output reg format_ok_o
);
  // --------------------------------------------------------------------
  // Pixel clock enable and data buffer
  // --------------------------------------------------------------------
  wire pix_en;
  wire fifo_valid;
  wire [DW-1:0] fifo_data;
  wire fifo_pop;

  pix_clk_sampler u_smp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pix_clk_i(pix_clk_i),
    .pix_en_o(pix_en)
  );

  // Pointer width follows the depth, so a deeper buffer still wraps right
  localparam FIFO_AW = $clog2(FIFO_DEPTH);

  sync_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .in_data_i(pix_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // --------------------------------------------------------------------
  // Format decode
  // --------------------------------------------------------------------
  reg [11:0] htot;
  reg [11:0] vtot;
  reg [11:0] hact;
  reg [11:0] vact;
  reg interlaced;
  reg progressive;

  always @* begin
    htot = `HTOT_480;
    vtot = `VTOT_480;
    hact = `HACT_720;
    vact = `VACT_480;
    interlaced = 1'b0;
    progressive = 1'b1;
    case (format_i)
      `FMT_480I_720: begin
        interlaced = 1'b1;
        progressive = 1'b0;
      end
      `FMT_480I_640: begin
        hact = `HACT_640;
        interlaced = 1'b1;
        progressive = 1'b0;
      end
      `FMT_480P_640: begin
        hact = `HACT_640;
      end
      `FMT_720P: begin
        htot = `HTOT_720;
        vtot = `VTOT_720;
        hact = `HACT_1280;
        vact = `VACT_720;
      end
      `FMT_1080I: begin
        htot = `HTOT_1080;
        vtot = `VTOT_1080;
        hact = `HACT_1920;
        vact = `VACT_1080;
        interlaced = 1'b1;
        progressive = 1'b0;
      end
      `FMT_1080P: begin
        htot = `HTOT_1080;
        vtot = `VTOT_1080;
        hact = `HACT_1920;
        vact = `VACT_1080;
      end
      `FMT_576I: begin
        htot = `HTOT_576;
        vtot = `VTOT_576;
        vact = `VACT_576;
        interlaced = 1'b1;
        progressive = 1'b0;
      end
      `FMT_768P_1280: begin
        htot = `HTOT_768A;
        vtot = `VTOT_768A;
        hact = `HACT_1280;
        vact = `VACT_768;
      end
      `FMT_768P_1366: begin
        htot = `HTOT_768B;
        vtot = `VTOT_768B;
        hact = `HACT_1366;
        vact = `VACT_768;
      end
      default: begin
      end
    endcase
  end

  // Progressive formats are refused without the native strap
  wire fmt_ok = (format_i <= `FMT_768P_1366) & (interlaced | native_strap_i);
  wire [11:0] vfield = interlaced ? {1'b0, vtot[11:1]} : vtot;
  wire [11:0] vact_f = interlaced ? {1'b0, vact[11:1]} : vact;

  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  reg [11:0] hcnt_q;
  reg [11:0] vcnt_q;
  reg second_q;
  // Second field is one line longer, giving odd totals such as 525
  wire [11:0] vlast = (interlaced && second_q) ? vfield : vfield - 12'h001;
  wire line_end = (hcnt_q == htot - 12'h001);
  wire frame_end = line_end & (vcnt_q == vlast);

  always @(posedge clk_i) begin
    if (rst_i || !fmt_ok) begin
      hcnt_q <= 12'h000;
      vcnt_q <= 12'h000;
      second_q <= 1'b0;
    end else if (pix_en) begin
      hcnt_q <= line_end ? 12'h000 : hcnt_q + 12'h001;
      if (line_end) begin
        vcnt_q <= frame_end ? 12'h000 : vcnt_q + 12'h001;
      end
      if (frame_end) begin
        second_q <= interlaced & ~second_q;
      end
    end
  end

  // --------------------------------------------------------------------
  // Period decode
  // --------------------------------------------------------------------
  // Layout per line: active, right border, blank(front porch, sync, back
  // porch), left border. Left border sits at the end before the wrap.
  wire [11:0] hbord_r_end = hact + `BORDER_W;
  wire [11:0] hbord_l_beg = htot - `BORDER_W;
  wire [11:0] hs_beg = hbord_r_end + `HFP_W;
  wire [11:0] hs_end = hs_beg + `HSYNC_W;
  wire [11:0] vbord_b_end = vact_f + `BORDER_L;
  wire [11:0] vbord_t_beg = vlast;
  wire [11:0] vs_beg = vbord_b_end + `VFP_L;
  wire [11:0] vs_end = vs_beg + `VSYNC_L;
  wire [11:0] half_line = {1'b0, htot[11:1]};

  // Half-open window test shared by the blank and sync decodes
  function in_span;
    input [11:0] pos;
    input [11:0] lo;
    input [11:0] hi;
    begin
      in_span = (pos >= lo) && (pos < hi);
    end
  endfunction

  wire h_act = hcnt_q < hact;
  wire h_blank = in_span(hcnt_q, hbord_r_end, hbord_l_beg);
  wire h_bord = !h_act && !h_blank;
  wire v_act = vcnt_q < vact_f;
  wire v_blank = in_span(vcnt_q, vbord_b_end, vbord_t_beg);
  wire v_bord = !v_act && !v_blank;
  // Porch widths keep sync start clear of the blank start
  wire h_sync = h_blank && in_span(hcnt_q, hs_beg, hs_end);
  // First field: vsync edges at hs_beg inside the line, aligned with hsync start.
  // Second field: edges moved to half line, ahead of the hsync pulse.
  wire v_in = in_span(vcnt_q, vs_beg, vs_end);
  wire v_prev = in_span(vcnt_q, vs_beg + 12'h001, vs_end + 12'h001);
  // Lines of the vertical blank that follow the field's vsync
  wire fid_late = vcnt_q > vs_end;
  wire v_sync_p = v_blank && (v_in && hcnt_q >= hs_beg || v_prev && hcnt_q < hs_beg);
  wire v_sync_i = v_blank && (v_in && hcnt_q >= half_line || v_prev && hcnt_q < half_line);
  wire v_sync = (interlaced && second_q) ? v_sync_i : v_sync_p;
  wire show = h_act && v_act && fmt_ok;
  assign fifo_pop = pix_en & show;

  // --------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      hblank_o <= 1'b1;
      vblank_o <= 1'b1;
      border_o <= 1'b0;
      active_o <= 1'b0;
      field_identity_o <= 1'b1;
      underrun_o <= 1'b0;
      digital_port_b_o <= {DW{1'b0}};
      digital_port_c_o <= {DW{1'b0}};
      format_ok_o <= 1'b0;
    end else begin
      format_ok_o <= fmt_ok;
      if (pix_en) begin
        hsync_o <= h_sync & fmt_ok;
        vsync_o <= v_sync & fmt_ok;
        hblank_o <= h_blank | ~fmt_ok;
        vblank_o <= v_blank | ~fmt_ok;
        border_o <= (h_bord & !v_blank | v_bord & !h_blank) & fmt_ok;
        active_o <= show;
        // Flips inside vertical blank once the field's vsync is over, so the
        // first field's vsync still goes out with the mark high
        field_identity_o <= ~interlaced | ~(fid_late ^ second_q);
        underrun_o <= show & ~fifo_valid;
        // Only pipe A exists here; pipe B data comes in from outside
        digital_port_b_o <= port_b_sel_pipe_b_i ? pipe_b_data_i :
                            (show ? fifo_data : {DW{1'b0}});
        // Combined mode ignores the port C select and sends pipe A to C for the wide pixel clock
        digital_port_c_o <= (port_c_sel_pipe_b_i && !dual_port_i) ? pipe_b_data_i :
                            (show ? fifo_data : {DW{1'b0}});
      end
    end
  end
endmodule

// [src/pix_clk_sampler.v]
/*
  Samples the pixel clock pin into the system clock domain and emits a
  one-cycle enable per rising edge of the pixel clock.
  Assumes the pixel clock is well below half of clk_i in the bench.
*/
`timescale 1ns/1ps
module pix_clk_sampler (
  input wire clk_i,
  input wire rst_i,
  input wire pix_clk_i,
  output wire pix_en_o
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pix_clk_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pix_en_o = sync_q & ~prev_q;
endmodule

// [src/sync_fifo.v]
/*
  Synchronous FIFO with valid/ready on both sides, parameter width and depth.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sync_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
    if (rst_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// [tb/disp_timing_props.sv]
/* Checker on the timing generator's ports.
   Assumes a bind to the top module, one clock, synchronous reset. */
`timescale 1ns/1ps
module disp_timing_checker (
  input wire clk_i,
  input wire rst_i,
  input wire hsync_o,
  input wire vsync_o,
  input wire hblank_o,
  input wire vblank_o,
  input wire border_o,
  input wire active_o,
  input wire field_identity_o,
  input wire underrun_o,
  input wire format_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------
  // Properties
  // ----------------
  property p_hs_blank; hsync_o |-> hblank_o; endproperty
  a_hs_blank: assert property (p_hs_blank) else $error("hsync outside hblank");
  property p_vs_blank; vsync_o |-> vblank_o; endproperty
  a_vs_blank: assert property (p_vs_blank) else $error("vsync outside vblank");
  property p_hs_late; $rose(hsync_o) |-> $past(hblank_o); endproperty
  a_hs_late: assert property (p_hs_late) else $error("hsync starts with hblank");
  property p_vs_late; $rose(vsync_o) |-> $past(vblank_o); endproperty
  a_vs_late: assert property (p_vs_late) else $error("vsync starts with vblank");
  property p_act; active_o |-> !(hblank_o || vblank_o || border_o); endproperty
  a_act: assert property (p_act) else $error("active overlaps blank or border");
  property p_border; $rose(hblank_o) && !vblank_o |-> $past(border_o); endproperty
  a_border: assert property (p_border) else $error("no border before hblank");
  // Front porch is 8 pixels of 8 clocks each
  property p_porch; $rose(hblank_o) |-> ##64 $rose(hsync_o); endproperty
  a_porch: assert property (p_porch) else $error("front porch length wrong");
  property p_fld; $fell(field_identity_o) |-> vblank_o; endproperty
  a_fld: assert property (p_fld) else $error("field mark falls outside vblank");
  property p_first; $rose(vsync_o) && field_identity_o |-> $rose(hsync_o); endproperty
  a_first: assert property (p_first) else $error("first field vsync not on hsync");
  property p_ok; active_o |-> format_ok_o; endproperty
  a_ok: assert property (p_ok) else $error("active with refused format");
  c_act: cover property ($rose(active_o));
  c_hs: cover property ($rose(hsync_o));
  c_under: cover property ($rose(underrun_o));
endmodule

// [tb/field_sink.sv]
/* Downstream encoder model: tells the fields apart by where vsync
   rises against hsync. Assumes it samples in the clk_i domain. */
`timescale 1ns/1ps
module field_sink (
  input wire clk_i,
  input wire rst_i,
  input wire hsync_i,
  input wire vsync_i,
  output int first_cnt_o,
  output int second_cnt_o
);
  logic hs_q;
  logic vs_q;
  always @(posedge clk_i) begin
    hs_q <= hsync_i;
    vs_q <= vsync_i;
    if (rst_i) begin
      first_cnt_o <= 0;
      second_cnt_o <= 0;
    end else if (vsync_i && !vs_q) begin
      if (hsync_i && !hs_q) first_cnt_o <= first_cnt_o + 1;
      else second_cnt_o <= second_cnt_o + 1;
    end
  end
endmodule

// [tb/test_display_pipe_timing_generator.sv]
/* Bench: format table, then buffer, port and reset cases.
   Assumes 8 ns clk_i and a free 64 ns pixel clock. */
`timescale 1ns/1ps
module test_display_pipe_timing_generator;
  typedef struct packed {
    logic [3:0] fmt;
    logic strap;
    logic ok;
    logic [11:0] htot;
    logic [11:0] hact;
  } row_t;
  logic clk_i = 0;
  logic rst_i = 1;
  logic pix_clk_i = 0;
  logic native_strap_i = 1;
  logic [3:0] format_i = 4'hf;
  logic dual_port_i = 0;
  logic b_sel = 0;
  logic c_sel = 0;
  logic pix_valid_i = 0;
  logic [23:0] pix_data_i = 24'h0;
  logic [23:0] pipe_b_data_i = 24'h0;
  wire pix_ready_o, hsync_o, vsync_o, hblank_o, vblank_o, border_o, active_o;
  wire field_identity_o, underrun_o, format_ok_o;
  wire [23:0] port_b, port_c;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int t0, ta, n, f1, f2;
  // Zero totals mark rows that only check format acceptance
  row_t rows [7] = '{
    '{4'h3, 1'b1, 1'b1, 12'd858, 12'd640},
    '{4'h4, 1'b1, 1'b1, 12'd1650, 12'd1280},
    '{4'h9, 1'b1, 1'b1, 12'd1656, 12'd1366},
    '{4'h3, 1'b0, 1'b0, 12'd0, 12'd0},
    '{4'h6, 1'b0, 1'b0, 12'd0, 12'd0},
    '{4'h0, 1'b0, 1'b1, 12'd0, 12'd0}, // Fixed totals, nothing to trim
    '{4'ha, 1'b1, 1'b0, 12'd0, 12'd0}};
  initial forever #4 clk_i = ~clk_i;
  initial begin
    #3;
    forever #32 pix_clk_i = ~pix_clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  display_pipe_timing_generator uut (.clk_i(clk_i), .rst_i(rst_i), .pix_clk_i(pix_clk_i),
    .native_strap_i(native_strap_i), .format_i(format_i), .dual_port_i(dual_port_i),
    .port_b_sel_pipe_b_i(b_sel), .port_c_sel_pipe_b_i(c_sel),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_data_i(pix_data_i),
    .pipe_b_data_i(pipe_b_data_i), .hsync_o(hsync_o), .vsync_o(vsync_o),
    .hblank_o(hblank_o), .vblank_o(vblank_o), .border_o(border_o), .active_o(active_o),
    .field_identity_o(field_identity_o), .underrun_o(underrun_o),
    .digital_port_b_o(port_b), .digital_port_c_o(port_c), .format_ok_o(format_ok_o));
  field_sink sink (.clk_i(clk_i), .rst_i(rst_i), .hsync_i(hsync_o), .vsync_i(vsync_o),
    .first_cnt_o(f1), .second_cnt_o(f2));
  // ----------------
  // Tasks
  // ----------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d fields %0d/%0d", check_count, n_fail, f1, f2);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_for(input int sel, input logic lvl);
    int k;
    k = 0;
    while (((sel != 0) ? active_o : hsync_o) !== lvl && k < 40000) begin
      tick(1);
      k++;
    end
    if (k >= 40000) begin
      n_fail++;
      $display("MISMATCH wait exp %0d seen timeout", lvl);
      summarize();
    end
  endtask
  task automatic do_reset();
    rst_i = 1;
    tick(2);
    rst_i = 0;
    tick(3);
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    tick(2);
    check("hsync", hsync_o, 0);
    check("hblank", hblank_o, 1);
    check("active", active_o, 0);
    check("field", field_identity_o, 1);
    check("fmt_ok", format_ok_o, 0);
    foreach (rows[i]) begin
      format_i = rows[i].fmt;
      native_strap_i = rows[i].strap;
      do_reset();
      check("fmt_ok", format_ok_o, rows[i].ok);
      if (rows[i].htot != 0) begin
        check("field", field_identity_o, 1);
        wait_for(0, 0);
        wait_for(0, 1);
        t0 = cyc;
        wait_for(1, 1);
        ta = cyc;
        wait_for(1, 0);
        check("border", border_o, 1);
        check("vblank", vblank_o, 0);
        check("vsync", vsync_o, 0);
        check("hact", cyc - ta, rows[i].hact * 8);
        wait_for(0, 0);
        wait_for(0, 1);
        check("htot", cyc - t0, rows[i].htot * 8);
      end
      $display("row %0d done", i);
    end
    // Invalid format holds counters, so the buffer fills with no drain
    format_i = 4'hf;
    do_reset();
    pix_valid_i = 1;
    n = 0;
    for (int i = 0; i < 9; i++) begin
      pix_data_i = 24'(i) + 24'ha0;
      if (pix_ready_o === 1'b1) n++;
      tick(1);
    end
    pix_valid_i = 0;
    check("accepted", n, 8);
    check("ready", pix_ready_o, 0);
    format_i = 4'h3;
    wait_for(1, 1);
    tick(3);
    for (int i = 0; i < 8; i++) begin
      check("port_b", port_b, 24'(i) + 24'ha0);
      tick(8);
    end
    check("underrun", underrun_o, 1);
    $display("buffer test done");
    b_sel = 1;
    c_sel = 1;
    pipe_b_data_i = 24'h5a5a5a;
    tick(16);
    check("port_b_sel", port_b, 24'h5a5a5a);
    check("port_c_sel", port_c, 24'h5a5a5a);
    // Combined mode: port C follows pipe A even while its select asks for B
    dual_port_i = 1;
    tick(16);
    wait_for(1, 1);
    wait_for(1, 0);
    check("port_c_dual", port_c, 24'h0);
    check("port_b_keep", port_b, 24'h5a5a5a);
    $display("port test done");
    // Mid-run reset: timing outputs idle until the first pixel edge after release, format_ok_o returns one clock after
    rst_i = 1;
    tick(2);
    check("active", active_o, 0);
    check("hblank", hblank_o, 1);
    rst_i = 0;
    tick(1);
    check("active", active_o, 0);
    check("vblank", vblank_o, 1);
    check("fmt_ok", format_ok_o, 1);
    $display("reset test done");
    summarize();
  end
endmodule
bind display_pipe_timing_generator disp_timing_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .hsync_o(hsync_o), .vsync_o(vsync_o), .hblank_o(hblank_o), .vblank_o(vblank_o),
  .border_o(border_o), .active_o(active_o), .field_identity_o(field_identity_o),
  .underrun_o(underrun_o), .format_ok_o(format_ok_o));
